// >>> usp_fabric_model.sv
// usp_fabric_model: fabric-side user logic driving the serial pins.
// assumes: core clock paces it; pins stay 4 cycles high or low each.
`timescale 1ns/1ps
module usp_fabric_model (
	input  wire logic clk_i,
	input  wire logic busy_i,
	input  wire logic dout_i,
	output logic      aclk_o,
	output logic      asel_o,
	output logic      adin_o,
	output logic      dclk_o,
	output logic      dsel_o,
	output logic      ddin_o,
	output logic      prog_o,
	output logic      eras_o
);
	// pins idle low
	initial begin
		{aclk_o, asel_o, adin_o, dclk_o} = 4'h0;
		{dsel_o, ddin_o, prog_o, eras_o} = 4'h0;
	end
	// one pulse, long enough for the two-flop syncs on both levels
	task automatic pulse(input bit dat);
		repeat (4) @(posedge clk_i);
		if (dat) dclk_o <= 1'b1; else aclk_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		dclk_o <= 1'b0;
		aclk_o <= 1'b0;
	endtask
	// nine address bits, msb first; line shows the inverse afterwards
	task automatic shift_addr(input logic [8:0] a);
		asel_o <= 1'b1;
		for (int i = 8; i >= 0; i--) begin
			adin_o <= a[i];
			pulse(0);
		end
		asel_o <= 1'b0;
		adin_o <= ~a[0];
	endtask
	// sixteen data bits, msb first
	task automatic shift_data(input logic [15:0] d);
		dsel_o <= 1'b1;
		for (int i = 15; i >= 0; i--) begin
			ddin_o <= d[i];
			pulse(1);
		end
		ddin_o <= ~d[0];
	endtask
	// next consecutive location
	task automatic step_addr;
		asel_o <= 1'b0;
		pulse(0);
	endtask
	// load the word at the address, then clock it out bit by bit
	task automatic read_ser(output logic [15:0] d);
		dsel_o <= 1'b0;
		pulse(1);
		dsel_o <= 1'b1;
		for (int i = 15; i >= 0; i--) begin
			@(posedge clk_i);
			d[i] = dout_i;
			if (i > 0) pulse(1);
		end
	endtask
	// request held until busy falls, then released; returns busy span
	task automatic op(input bit er, output int cyc);
		cyc = 0;
		if (er) eras_o <= 1'b1; else prog_o <= 1'b1;
		for (int i = 0; i < 20 && busy_i !== 1'b1; i++) @(posedge clk_i);
		while (busy_i === 1'b1 && cyc < 2000) begin
			@(posedge clk_i);
			cyc++;
		end
		prog_o <= 1'b0;
		eras_o <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
endmodule // usp_fabric_model

// >>> usp_flash.sv
// usp_flash: user flash array with serial address/data access,
// program and sector erase handshake, busy flag and divided oscillator.
// assumes: serial pins come from fabric logic on another clock and are
// synchronised here; the register port is on the core clock.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - 8192 bits stored as 512 words of 16 bits, 9-bit address
// - sector zero is 000h..0FFh, sector one is 100h..1FFh
// - erase clears one whole sector; whole array needs two erases
// - internal oscillator paces operations, divide-by-four copy driven out
// - divided clock typically 3.3 to 5.5 MHz, not adjustable
// - program or erase request starts a self-timed internal algorithm
// - busy stays high for the whole operation, drops when done
// - standard single-word read and stream read both supported
// - address clock with shift select low increments the address
// - array also programmed and read through the register port window
// - 9-bit serial address register, 16-bit serial data register
module usp_flash #(
	parameter int PROG_TICKS  = 16,
	parameter int ERASE_TICKS = 64
) (
	input  wire logic                CORE_CLK_I,
	input  wire logic                SYS_RST_I,
	input  wire logic                ADDR_REG_CLOCK_I,
	input  wire logic                ADDR_SHIFT_SELECT_I,
	input  wire logic                ADDR_SERIAL_I,
	input  wire logic                DATA_REG_CLOCK_I,
	input  wire logic                DATA_SHIFT_SELECT_I,
	input  wire logic                DATA_SERIAL_I,
	input  wire logic                PROGRAM_REQ_I,
	input  wire logic                ERASE_REQ_I,
	input  wire usp_pkg::usp_bus_req_t BUS_REQ_I,
	output logic                     DATA_SERIAL_O,
	output logic                     BUSY_O,
	output logic                     DIVIDED_INTERNAL_CLOCK_OUT_O,
	output logic [usp_pkg::DATA_W-1:0] BUS_RDATA_O
);
	import usp_pkg::*;

	// pin synchronisers: stage one feeds stage two only
	logic [PIN_N-1:0] sync1;
	logic [PIN_N-1:0] sync2;
	logic [PIN_N-1:0] sync3;
	logic [PIN_N-1:0] pins;
	assign pins = {ERASE_REQ_I, PROGRAM_REQ_I, DATA_SERIAL_I,
	               DATA_SHIFT_SELECT_I, DATA_REG_CLOCK_I, ADDR_SERIAL_I,
	               ADDR_SHIFT_SELECT_I, ADDR_REG_CLOCK_I};
	// stage three only delays stage two for the edge detectors
	always_ff @(posedge CORE_CLK_I) begin
		sync1 <= pins;
		sync2 <= sync1;
		sync3 <= sync2;
	end

	logic aclk_rise;
	logic dclk_rise;
	logic prog_s;
	logic erase_s;
	// edges are taken from stage two against its delayed copy
	assign aclk_rise = sync2[PIN_ACLK] & ~sync3[PIN_ACLK];
	assign dclk_rise = sync2[PIN_DCLK] & ~sync3[PIN_DCLK];
	assign prog_s    = sync2[PIN_PROG];
	assign erase_s   = sync2[PIN_ERAS];

	// internal oscillator: a tick enable every OSC_TICK_CYC cycles
	// rate is fixed by constants: no setting can tune the divided clock
	logic [7:0] osc_cnt;
	logic [7:0] next_osc_cnt;
	logic       osc_ph;
	logic       next_osc_ph;
	logic       osc_out;
	logic       next_osc_out;
	logic       osc_tick;
	logic       osc_en;
	logic       next_osc_en;
	always_comb begin
		osc_tick     = (osc_cnt == OSC_TICK_LAST);
		next_osc_cnt = osc_tick ? 8'h00 : osc_cnt + 8'h01;
		next_osc_ph  = osc_tick ? ~osc_ph : osc_ph;
		// divide by four: toggle every second tick, gated off when unused
		if (!osc_en) begin
			next_osc_out = 1'b0;
		end else if (osc_tick && osc_ph) begin
			next_osc_out = ~osc_out;
		end else begin
			next_osc_out = osc_out;
		end
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			osc_cnt <= 8'h00;
			osc_ph  <= 1'b0;
			osc_out <= 1'b0;
		end else begin
			osc_cnt <= next_osc_cnt;
			osc_ph  <= next_osc_ph;
			osc_out <= next_osc_out;
		end
	end
	assign DIVIDED_INTERNAL_CLOCK_OUT_O = osc_out;

	// storage: flip-flops, contents survive reset like flash would
	logic [DATA_W-1:0] mem [WORDS];
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_W-1:0] data_sr;
	logic [DATA_W-1:0] next_data_sr;

	// operation sequencer, paced by oscillator ticks
	usp_state_t  state;
	usp_state_t  next_state;
	logic [15:0] op_cnt;
	logic [15:0] next_op_cnt;
	logic        next_busy;
	logic        op_done;
	logic        erase_done;
	logic        erase_sect;
	always_comb begin
		next_state  = state;
		next_op_cnt = op_cnt;
		op_done     = 1'b0;
		erase_done  = 1'b0;
		case (state)
			ST_IDLE: begin
				next_op_cnt = 16'h0000;
				// program wins when both requests appear together
				if (prog_s) begin
					next_state = ST_PROG;
				end else if (erase_s) begin
					next_state = ST_ERASE;
				end
			end
			ST_PROG, ST_ERASE: begin
				if (osc_tick) begin
					next_op_cnt = op_cnt + 16'h0001;
				end
				if (osc_tick && (op_cnt == 16'((state == ST_PROG) ?
				    PROG_TICKS - 1 : ERASE_TICKS - 1))) begin
					op_done    = 1'b1;
					erase_done = (state == ST_ERASE);
					next_state = ST_RELEASE;
				end
			end
			ST_RELEASE: begin
				// request is held until busy falls; wait for its release
				if (!prog_s && !erase_s) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		next_busy = (next_state == ST_PROG) ||
		            (next_state == ST_ERASE);
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			state  <= ST_IDLE;
			op_cnt <= 16'h0000;
			BUSY_O <= 1'b0;
		end else begin
			state  <= next_state;
			op_cnt <= next_op_cnt;
			BUSY_O <= next_busy;
		end
	end
	// erase takes its sector from the address, so shift the address first
	assign erase_sect = addr[SECT_BIT];

	// serial address and data registers; frozen while an op runs
	logic idle;
	assign idle = (state == ST_IDLE) || (state == ST_RELEASE);
	always_comb begin
		next_addr    = addr;
		next_data_sr = data_sr;
		if (idle && aclk_rise) begin
			if (sync2[PIN_ASEL]) begin
				next_addr = {addr[ADDR_W-2:0], sync2[PIN_ADIN]};
			end else begin
				next_addr = addr + ADDR_STEP;
			end
		end
		if (idle && dclk_rise) begin
			if (sync2[PIN_DSEL]) begin
				next_data_sr = {data_sr[DATA_W-2:0],
				                sync2[PIN_DDIN]};
			end else begin
				next_data_sr = mem[addr];
			end
		end
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			addr          <= ADDR_ZERO;
			data_sr       <= DATA_ZERO;
			DATA_SERIAL_O <= 1'b0;
		end else begin
			addr          <= next_addr;
			data_sr       <= next_data_sr;
			DATA_SERIAL_O <= next_data_sr[DATA_W-1];
		end
	end

	// register port: status, control and a direct array window
	logic              bus_arr;
	logic              bus_wr_arr;
	logic [ADDR_W-1:0] bus_idx;
	logic [DATA_W-1:0] next_rdata;
	logic [DATA_W-1:0] wr_val;
	logic [ADDR_W-1:0] wr_idx;
	logic              wr_en;
	always_comb begin
		bus_arr    = BUS_REQ_I.addr[ARRAY_SEL];
		bus_idx    = BUS_REQ_I.addr[ADDR_W-1:0];
		bus_wr_arr = BUS_REQ_I.wr && bus_arr && state == ST_IDLE &&
		             !prog_s && !erase_s;
		next_osc_en = osc_en;
		if (BUS_REQ_I.wr && BUS_REQ_I.addr == REG_CTRL) begin
			next_osc_en = BUS_REQ_I.wdata[CTRL_OSC];
		end
		// read data fall back to zero unless a read is pending
		next_rdata = DATA_ZERO;
		if (BUS_REQ_I.rd) begin
			if (bus_arr) begin
				next_rdata = mem[bus_idx];
			end else if (BUS_REQ_I.addr == REG_STATUS) begin
				next_rdata[STAT_BUSY]  = BUSY_O;
				next_rdata[STAT_OSC]   = osc_en;
				next_rdata[STAT_STATE] = (state == ST_RELEASE);
			end else if (BUS_REQ_I.addr == REG_CTRL) begin
				next_rdata[CTRL_OSC] = osc_en;
			end
		end
		// flash can only clear bits: a word must be erased first
		if (op_done && state == ST_PROG) begin
			wr_en  = 1'b1;
			wr_idx = addr;
			wr_val = mem[addr] & data_sr;
		end else begin
			wr_en  = bus_wr_arr;
			wr_idx = bus_idx;
			wr_val = mem[bus_idx] & BUS_REQ_I.wdata;
		end
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			osc_en      <= 1'b0;
			BUS_RDATA_O <= DATA_ZERO;
		end else begin
			osc_en      <= next_osc_en;
			BUS_RDATA_O <= next_rdata;
		end
	end

	// array update: whole-sector erase or one word program
	// port writes need the idle state, so they never meet an erase
	always_ff @(posedge CORE_CLK_I) begin
		if (erase_done) begin
			for (int i = 0; i < WORDS; i++) begin
				if (i[SECT_BIT] == erase_sect) begin
					mem[i] <= ERASED;
				end
			end
		end else if (wr_en) begin
			mem[wr_idx] <= wr_val;
		end
	end

	// checks
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (SYS_RST_I);

	a_busy_on_start: assert property (
		state == ST_IDLE && (prog_s || erase_s) |=> BUSY_O)
		else $error("busy not raised on request");
	a_busy_during_op: assert property (
		state == ST_PROG || state == ST_ERASE |-> BUSY_O)
		else $error("busy low during operation");
	a_busy_falls_done: assert property (
		$fell(BUSY_O) |-> $past(op_done))
		else $error("busy fell before completion");
	a_wait_release: assert property (
		state == ST_RELEASE && (prog_s || erase_s) |=>
		state == ST_RELEASE && !BUSY_O)
		else $error("left release with request held");
	a_addr_incr: assert property (
		idle && aclk_rise && !sync2[PIN_ASEL] |=>
		addr == $past(addr) + ADDR_STEP)
		else $error("stream address did not step");
	a_addr_shift_in: assert property (
		idle && aclk_rise && sync2[PIN_ASEL] |=>
		addr[0] == $past(sync2[PIN_ADIN]) &&
		addr[ADDR_W-1:1] == $past(addr[ADDR_W-2:0]))
		else $error("address bit not shifted");
	a_word_load: assert property (
		idle && dclk_rise && !sync2[PIN_DSEL] |=>
		data_sr == $past(mem[addr]) &&
		DATA_SERIAL_O == $past(mem[addr][DATA_W-1]))
		else $error("word not loaded for read");
	a_data_shift: assert property (
		idle && dclk_rise && sync2[PIN_DSEL] |=>
		DATA_SERIAL_O == $past(data_sr[DATA_W-2]))
		else $error("serial data did not advance");
	a_erase_sector: assert property (
		erase_done && !erase_sect |=>
		mem[ADDR_ZERO] == ERASED && mem[SECT0_TOP] == ERASED &&
		mem[SECT1_BASE] == $past(mem[SECT1_BASE]))
		else $error("sector erase wrong span");
	a_bus_array_rd: assert property (
		BUS_REQ_I.rd && bus_arr && !wr_en && !erase_done |=>
		BUS_RDATA_O == $past(mem[bus_idx]))
		else $error("array read data wrong");
	a_osc_edges: assert property (
		$changed(osc_out) && $past(osc_en) |->
		$past(osc_tick) && $past(osc_ph))
		else $error("divided clock toggled off tick");

	// register port, serial freeze, write path, oscillator gating and release checks
	a_rdata_zero: assert property (
		!BUS_REQ_I.rd |=> BUS_RDATA_O == DATA_ZERO)
		else $error("read data stood past its cycle");
	a_ops_freeze: assert property (
		!idle |=> addr == $past(addr) && data_sr == $past(data_sr))
		else $error("serial registers moved during operation");
	a_prog_word: assert property (
		op_done && state == ST_PROG |=>
		mem[$past(addr)] == $past(mem[addr] & data_sr))
		else $error("programmed word wrong");
	a_osc_gated: assert property (
		!osc_en |=> !osc_out)
		else $error("divided clock ran while disabled");
	a_release_idle: assert property (
		state == ST_RELEASE && !prog_s && !erase_s |=>
		state == ST_IDLE)
		else $error("release not left after requests dropped");

	c_program: cover property (state == ST_PROG ##1 state == ST_RELEASE);
	c_erase:   cover property (erase_done && erase_sect);
	c_stream:  cover property (idle && aclk_rise && !sync2[PIN_ASEL]);
	c_bus_rd:  cover property (BUS_REQ_I.rd && bus_arr);
	c_release: cover property (state == ST_RELEASE && !prog_s && !erase_s);
endmodule // usp_flash

// >>> usp_flash_test.sv
// usp_flash_test: self-checking scenarios for the user flash block.
// assumes: fabric model drives the pins, bench drives the register port.
`timescale 1ns/1ps
module usp_flash_test;
	import usp_pkg::*;
	localparam int PT = 2;
	localparam int ET = 6;
	logic         clk, rst, aclk, asel, adin, dclk, dsel, ddin;
	logic         prog, eras, dout, busy, osc;
	logic [15:0]  rdata;
	usp_bus_req_t req;
	int           errors, samples_checked;

	usp_flash #(.PROG_TICKS(PT), .ERASE_TICKS(ET)) usp_flash_i (
		.CORE_CLK_I(clk), .SYS_RST_I(rst), .ADDR_REG_CLOCK_I(aclk),
		.ADDR_SHIFT_SELECT_I(asel), .ADDR_SERIAL_I(adin),
		.DATA_REG_CLOCK_I(dclk), .DATA_SHIFT_SELECT_I(dsel),
		.DATA_SERIAL_I(ddin), .PROGRAM_REQ_I(prog), .ERASE_REQ_I(eras),
		.BUS_REQ_I(req), .DATA_SERIAL_O(dout), .BUSY_O(busy),
		.DIVIDED_INTERNAL_CLOCK_OUT_O(osc), .BUS_RDATA_O(rdata));
	usp_fabric_model usp_fabric_model_i (
		.clk_i(clk), .busy_i(busy), .dout_i(dout), .aclk_o(aclk),
		.asel_o(asel), .adin_o(adin), .dclk_o(dclk), .dsel_o(dsel),
		.ddin_o(ddin), .prog_o(prog), .eras_o(eras));

	// 200 MHz core clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string n, input logic [15:0] e, g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus_wr(input logic [9:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		req <= '0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rchk(input string n, input logic [9:0] a, logic [15:0] e);
		@(posedge clk);
		req <= '{1'b0, 1'b1, a, DATA_ZERO};
		@(posedge clk);
		req <= '0;
		#1 chk(n, e, rdata);
	endtask
	// busy span must match the tick count within one tick
	task automatic span(input string n, input int c, input int t);
		chk(n, 16'h0001, 16'(c >= (t - 1) * OSC_TICK_CYC &&
			c <= (t + 1) * OSC_TICK_CYC));
	endtask
	// sector one first, so the sector zero erase finds sector one defined
	task automatic t_erase_all;
		int c;
		usp_fabric_model_i.shift_addr(SECT1_BASE);
		usp_fabric_model_i.op(1, c);
		span("erase1 busy", c, ET);
		usp_fabric_model_i.shift_addr(ADDR_ZERO);
		usp_fabric_model_i.op(1, c);
		span("erase0 busy", c, ET);
		rchk("w000", 10'h200, ERASED);
		rchk("w0ff", 10'h2FF, ERASED);
		rchk("w100", 10'h300, ERASED);
		rchk("w1ff", 10'h3FF, ERASED);
		$display("test erase_all done");
	endtask
	task automatic t_prog_serial;
		int c;
		logic [15:0] d;
		usp_fabric_model_i.shift_addr(SECT0_TOP);
		usp_fabric_model_i.shift_data(16'hA5C3);
		usp_fabric_model_i.op(0, c);
		span("prog busy", c, PT);
		rchk("prog word", 10'h2FF, 16'hA5C3);
		rchk("next sect", 10'h300, ERASED);
		usp_fabric_model_i.read_ser(d);
		chk("serial read", 16'hA5C3, d);
		$display("test prog_serial done");
	endtask
	task automatic t_stream;
		logic [15:0] d;
		bus_wr(10'h300, 16'h3C5A);
		rchk("port word", 10'h300, 16'h3C5A);
		usp_fabric_model_i.shift_addr(SECT0_TOP);
		usp_fabric_model_i.step_addr();
		usp_fabric_model_i.read_ser(d);
		chk("stream 100", 16'h3C5A, d);
		usp_fabric_model_i.step_addr();
		usp_fabric_model_i.read_ser(d);
		chk("stream 101", ERASED, d);
		$display("test stream done");
	endtask
	task automatic t_sector_keep;
		int c;
		usp_fabric_model_i.shift_addr(9'h055);
		// status is read while the erase still runs
		fork
			usp_fabric_model_i.op(1, c);
			begin
				repeat (8) @(posedge clk);
				rchk("status busy", REG_STATUS,
					16'(1 << STAT_BUSY));
			end
		join
		span("erase keep busy", c, ET);
		rchk("sect0 clear", 10'h2FF, ERASED);
		rchk("sect1 kept", 10'h300, 16'h3C5A);
		$display("test sector_keep done");
	endtask
	task automatic t_osc_bus;
		int n;
		logic p;
		rchk("unmapped", 10'h002, DATA_ZERO);
		// a non-zero word first, so the drop to zero is visible
		rchk("drop src", 10'h300, 16'h3C5A);
		@(posedge clk);
		#1 chk("rdata drop", DATA_ZERO, rdata);
		bus_wr(REG_CTRL, 16'h0001);
		rchk("status", REG_STATUS, 16'(1 << STAT_OSC));
		n = 0;
		repeat (440) begin
			p = osc;
			@(posedge clk);
			#1 if (p === 1'b0 && osc === 1'b1) n++;
		end
		c_osc: chk("osc rises", 16'h0001,
			16'(n >= 9 && n <= 11));
		bus_wr(REG_CTRL, DATA_ZERO);
		repeat (60) @(posedge clk);
		chk("osc off", 16'h0000, 16'(osc));
		$display("test osc_bus done");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// hang guard, far beyond the fewer than two thousand cycles the tests need
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		end_of_test();
	end
	initial begin
		errors = 0;
		samples_checked = 0;
		rst = 1'b1;
		req = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1 chk("rst busy", 16'h0000, 16'(busy));
		chk("rst dout", 16'h0000, 16'(dout));
		chk("rst osc", 16'h0000, 16'(osc));
		chk("rst rdata", DATA_ZERO, rdata);
		repeat (4) @(posedge clk);
		t_erase_all();
		t_prog_serial();
		t_stream();
		t_sector_keep();
		t_osc_bus();
		end_of_test();
	end
endmodule // usp_flash_test

// >>> usp_pkg.sv
// usp_pkg: constants and types for the user flash serial access block.
// assumes: one 200 MHz core clock, synchronous active-high reset.
package usp_pkg;
	// array shape
	localparam int          ADDR_W     = 9;
	localparam int          DATA_W     = 16;
	localparam int          WORDS      = 512;
	localparam int          SECT_BIT   = 8;
	localparam logic [15:0] ERASED     = 16'hFFFF;
	localparam logic [8:0]  ADDR_ZERO  = 9'h000;
	localparam logic [8:0]  ADDR_STEP  = 9'h001;
	localparam logic [8:0]  SECT0_TOP  = 9'h0FF;
	localparam logic [8:0]  SECT1_BASE = 9'h100;
	localparam logic [8:0]  ARRAY_TOP  = 9'h1FF;
	// oscillator: typical output sits inside 3.3 .. 5.5 MHz
	localparam int OSC_MIN_KHZ  = 3_300;
	localparam int OSC_MAX_KHZ  = 5_500;
	localparam int OSC_TYP_KHZ  = (OSC_MIN_KHZ + OSC_MAX_KHZ) / 2;
	localparam int OSC_DIV      = 4;
	localparam int CLK_KHZ      = 200_000;
	localparam int OSC_TICK_CYC = CLK_KHZ / (OSC_DIV * OSC_TYP_KHZ);
	localparam logic [7:0] OSC_TICK_LAST = 8'(OSC_TICK_CYC - 1);
	// register port map
	localparam int          BUS_AW       = 10;
	localparam int          ARRAY_SEL    = 9;
	localparam logic [9:0]  REG_STATUS   = 10'h000;
	localparam logic [9:0]  REG_CTRL     = 10'h001;
	localparam int          STAT_BUSY    = 0;
	localparam int          STAT_OSC     = 1;
	localparam int          STAT_STATE   = 2;
	localparam int          CTRL_OSC     = 0;
	localparam logic [15:0] DATA_ZERO    = 16'h0000;
	// synchronised pin positions
	localparam int PIN_ACLK = 0;
	localparam int PIN_ASEL = 1;
	localparam int PIN_ADIN = 2;
	localparam int PIN_DCLK = 3;
	localparam int PIN_DSEL = 4;
	localparam int PIN_DDIN = 5;
	localparam int PIN_PROG = 6;
	localparam int PIN_ERAS = 7;
	localparam int PIN_N    = 8;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [BUS_AW-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} usp_bus_req_t;

	typedef enum {ST_IDLE, ST_PROG, ST_ERASE, ST_RELEASE} usp_state_t;
endpackage
